// *** pkg/dma0_pkg.sv ***
package dma0_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [7:0]  IDX_MEM_ADDR_A = 8'h20;
  localparam logic [7:0]  IDX_COUNT_A    = 8'h24;
  localparam logic [7:0]  IDX_IO_ADDR_A  = 8'h26;
  localparam logic [7:0]  IDX_CTRL_A     = 8'h27;
  localparam logic [7:0]  IDX_MEM_ADDR_B = 8'h28;
  localparam logic [7:0]  IDX_IRQ_STATUS = 8'h30;
  localparam logic [7:0]  IDX_IRQ_MASK   = 8'h31;

  localparam logic [11:0] ADDR_MEM_ADDR_A = {2'h0, IDX_MEM_ADDR_A, 2'h0};
  localparam logic [11:0] ADDR_COUNT_A    = {2'h0, IDX_COUNT_A, 2'h0};
  localparam logic [11:0] ADDR_IO_ADDR_A  = {2'h0, IDX_IO_ADDR_A, 2'h0};
  localparam logic [11:0] ADDR_CTRL_A     = {2'h0, IDX_CTRL_A, 2'h0};
  localparam logic [11:0] ADDR_MEM_ADDR_B = {2'h0, IDX_MEM_ADDR_B, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STATUS = {2'h0, IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] ADDR_IRQ_MASK   = {2'h0, IDX_IRQ_MASK, 2'h0};

  // Field layout and reset values
  localparam int          MEM_ADDR_W      = 24;
  localparam logic [7:0]  MEM_ADDR_TOP    = 8'hff;
  localparam logic [23:0] MEM_ADDR_RESET  = 24'h000000;
  localparam logic [15:0] COUNT_RESET     = 16'h0000;
  localparam logic [7:0]  IO_ADDR_RESET   = 8'h00;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [0:0]  IRQ_STATUS_RST  = 1'h0;
  localparam logic [0:0]  IRQ_MASK_RST    = 1'h1;
  localparam int          IRQ_DONE_BIT    = 0;
  localparam logic [2:0]  SEL_TX_EMPTY    = 3'h4;
  localparam logic [2:0]  SEL_RX_FULL     = 3'h5;
  localparam logic [1:0]  SEL_FULL_MODE   = 2'h3;

  // Sub-channel A control byte, bit 7 down to bit 0
  typedef struct packed {
    logic       xfer_enable_bit;
    logic       xfer_size_bit;
    logic       step_direction_bit;
    logic       repeat_enable_bit;
    logic       xfer_irq_enable_bit;
    logic       act_select_hi;
    logic       act_select_mid;
    logic       act_select_lo;
  } ctrl_t;

  // One transfer handed to the bus side
  typedef struct packed {
    logic [23:0] source_address;
    logic [23:0] dest_address;
    logic [7:0]  io_address;
    logic        word;
    logic        full_mode;
  } xfer_t;

endpackage : dma0_pkg

// *** hdl/addr_stepper.sv ***
`timescale 1ns/100ps
// Next memory address: hold, or step up or down by one or two
module addr_stepper #(
  parameter int WIDTH = 24
) (
  // Current address and controls
  input  wire logic [WIDTH-1:0] addr,
  input  wire logic             step_en,
  input  wire logic             down,
  input  wire logic             word,
  // Stepped address
  output      logic [WIDTH-1:0] nxt_addr
);

  wire logic [WIDTH-1:0] stride = word ? WIDTH'(2) : WIDTH'(1);

  assign nxt_addr = !step_en ? addr :
                    down     ? addr - stride : addr + stride;

endmodule : addr_stepper

// *** hdl/dma0_chan.sv ***
`timescale 1ns/100ps
module dma0_chan (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output      logic [31:0]           prdata,
  output      logic                  pready,
  output      logic                  pslverr,
  // Activation sources, same clock
  input  wire logic [3:0]            timer_unit_evt,
  input  wire logic                  serial_unit_tx_empty,
  input  wire logic                  serial_unit_rx_full,
  // External request pin, active low, asynchronous
  input  wire logic                  dreq_n,
  // Transfer requests
  output      logic                  xfer_valid,
  output      dma0_pkg::xfer_t       xfer,
  output      logic                  xfer_enabled,
  // Interrupt
  output      logic                  irq
);

  // Register state
  logic [23:0]          mem_addr_a_ff;
  logic [23:0]          mem_addr_b_ff;
  logic [23:0]          shadow_addr_a_ff;
  logic [15:0]          count_ff;
  logic [15:0]          shadow_count_ff;
  logic [7:0]           io_addr_ff;
  dma0_pkg::ctrl_t      ctrl_ff;
  logic [0:0]           status_ff;
  logic [0:0]           mask_ff;
  logic                 irq_ff;
  logic                 xfer_valid_ff;
  dma0_pkg::xfer_t      xfer_ff;
  logic                 pready_ff;
  logic                 pslverr_ff;
  logic [31:0]          prdata_ff;
  logic                 dreq_s1_ff;
  logic                 dreq_s2_ff;
  logic                 dreq_s3_ff;
  logic                 dreq_stable_ff;

  // Bus decode
  wire logic       acc_req   = psel && penable && !pready_ff;
  wire logic       acc_done  = psel && penable && pready_ff;
  wire logic       hit_mar_a = paddr == dma0_pkg::ADDR_MEM_ADDR_A;
  wire logic       hit_cnt   = paddr == dma0_pkg::ADDR_COUNT_A;
  wire logic       hit_io    = paddr == dma0_pkg::ADDR_IO_ADDR_A;
  wire logic       hit_ctrl  = paddr == dma0_pkg::ADDR_CTRL_A;
  wire logic       hit_mar_b = paddr == dma0_pkg::ADDR_MEM_ADDR_B;
  wire logic       hit_stat  = paddr == dma0_pkg::ADDR_IRQ_STATUS;
  wire logic       hit_mask  = paddr == dma0_pkg::ADDR_IRQ_MASK;
  wire logic       hit_any   = hit_mar_a || hit_cnt || hit_io || hit_ctrl
                               || hit_mar_b || hit_stat || hit_mask;
  wire logic       wr_fire   = acc_done && pwrite && hit_any;
  wire logic       wr_mar_a  = wr_fire && hit_mar_a;
  wire logic       wr_cnt    = wr_fire && hit_cnt;
  wire logic       wr_io     = wr_fire && hit_io;
  wire logic       wr_ctrl   = wr_fire && hit_ctrl;
  wire logic       wr_mar_b  = wr_fire && hit_mar_b;
  wire logic       wr_stat   = wr_fire && hit_stat;
  wire logic       wr_mask   = wr_fire && hit_mask;

  // Top byte of each address register is fixed high
  wire logic [31:0] rd_mar_a = {dma0_pkg::MEM_ADDR_TOP, mem_addr_a_ff};
  wire logic [31:0] rd_mar_b = {dma0_pkg::MEM_ADDR_TOP, mem_addr_b_ff};
  wire logic [31:0] rdata =
    hit_mar_a ? rd_mar_a :
    hit_mar_b ? rd_mar_b :
    hit_cnt   ? {16'h0000, count_ff} :
    hit_io    ? {24'h000000, io_addr_ff} :
    hit_ctrl  ? {24'h000000, ctrl_ff} :
    hit_stat  ? {31'h00000000, status_ff} :
    hit_mask  ? {31'h00000000, mask_ff} : 32'h00000000;

  // Mode decode
  wire logic [2:0] sel       = {ctrl_ff.act_select_hi, ctrl_ff.act_select_mid,
                                ctrl_ff.act_select_lo};
  wire logic       full_mode = sel[2:1] == dma0_pkg::SEL_FULL_MODE;
  wire logic       io_mode   = !full_mode && !ctrl_ff.repeat_enable_bit;
  wire logic       rpt_mode  = !full_mode && ctrl_ff.repeat_enable_bit
                               && !ctrl_ff.xfer_irq_enable_bit;
  wire logic       idle_mode = !full_mode && ctrl_ff.repeat_enable_bit
                               && ctrl_ff.xfer_irq_enable_bit;
  // In full mode bits 5 and 4 are the source direction and step enable
  wire logic       src_direction_bit   = ctrl_ff.step_direction_bit;
  wire logic       src_step_enable_bit = ctrl_ff.repeat_enable_bit;

  // Pin edge: counts only once the second and third stages agree
  wire logic       dreq_agree = dreq_s2_ff == dreq_s3_ff;
  wire logic       dreq_fall  = dreq_agree && dreq_stable_ff && !dreq_s3_ff;

  // Activation source select
  wire logic       trig =
    full_mode                      ? dreq_fall :
    !sel[2]                        ? timer_unit_evt[sel[1:0]] :
    sel == dma0_pkg::SEL_TX_EMPTY  ? serial_unit_tx_empty :
                                     serial_unit_rx_full;
  wire logic       fire      = ctrl_ff.xfer_enable_bit && trig;
  wire logic       last      = count_ff == 16'h0001;
  wire logic       finish    = fire && last && !rpt_mode;
  wire logic       done_evt  = finish && ctrl_ff.xfer_irq_enable_bit;

  // Address stepping; idle mode keeps the memory address put
  wire logic       step_a_en   = full_mode ? src_step_enable_bit
                                           : !idle_mode;
  wire logic       step_a_down = full_mode ? src_direction_bit
                                           : ctrl_ff.step_direction_bit;
  wire logic [23:0] stepped_a;

  addr_stepper #(
    .WIDTH    (dma0_pkg::MEM_ADDR_W)
  ) u_step_a (
    .addr     (mem_addr_a_ff),
    .step_en  (step_a_en),
    .down     (step_a_down),
    .word     (ctrl_ff.xfer_size_bit),
    .nxt_addr (stepped_a)
  );

  // Next values
  wire logic [23:0] nxt_mem_addr_a =
    wr_mar_a          ? pwdata[23:0] :
    fire && last && rpt_mode ? shadow_addr_a_ff :
    fire              ? stepped_a : mem_addr_a_ff;
  wire logic [15:0] nxt_count =
    wr_cnt            ? pwdata[15:0] :
    fire && last && rpt_mode ? shadow_count_ff :
    fire              ? count_ff - 16'h0001 : count_ff;
  // A software write in the same cycle wins over the hardware clear
  wire dma0_pkg::ctrl_t nxt_ctrl =
    wr_ctrl ? dma0_pkg::ctrl_t'(pwdata[7:0]) :
    finish  ? dma0_pkg::ctrl_t'({1'b0, ctrl_ff[6:0]}) : ctrl_ff;
  // Set wins over write-one-to-clear
  wire logic [0:0]  nxt_status =
    (status_ff & ~(wr_stat ? pwdata[0:0] : 1'b0)) | done_evt;
  wire dma0_pkg::xfer_t nxt_xfer = '{
    source_address : mem_addr_a_ff,
    dest_address   : mem_addr_b_ff,
    io_address     : full_mode ? 8'h00 : io_addr_ff,
    word           : ctrl_ff.xfer_size_bit,
    full_mode      : full_mode
  };

  // APB answer: one wait state, data and error come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else begin
      pready_ff  <= acc_req;
      pslverr_ff <= acc_req && !hit_any;
      if (acc_req) begin
        prdata_ff <= pwrite ? 32'h00000000 : rdata;
      end
    end
  end

  // Request pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dreq_s1_ff     <= 1'b1;
      dreq_s2_ff     <= 1'b1;
      dreq_s3_ff     <= 1'b1;
      dreq_stable_ff <= 1'b1;
    end else begin
      dreq_s1_ff <= dreq_n;
      dreq_s2_ff <= dreq_s1_ff;
      dreq_s3_ff <= dreq_s2_ff;
      if (dreq_agree) begin
        dreq_stable_ff <= dreq_s3_ff;
      end
    end
  end

  // Channel registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr_a_ff    <= dma0_pkg::MEM_ADDR_RESET;
      mem_addr_b_ff    <= dma0_pkg::MEM_ADDR_RESET;
      shadow_addr_a_ff <= dma0_pkg::MEM_ADDR_RESET;
      count_ff         <= dma0_pkg::COUNT_RESET;
      shadow_count_ff  <= dma0_pkg::COUNT_RESET;
      io_addr_ff       <= dma0_pkg::IO_ADDR_RESET;
      ctrl_ff          <= dma0_pkg::ctrl_t'(dma0_pkg::CTRL_RESET);
    end else begin
      mem_addr_a_ff <= nxt_mem_addr_a;
      count_ff      <= nxt_count;
      ctrl_ff       <= nxt_ctrl;
      if (wr_mar_a) begin
        shadow_addr_a_ff <= pwdata[23:0];
      end
      if (wr_cnt) begin
        shadow_count_ff <= pwdata[15:0];
      end
      if (wr_mar_b) begin
        mem_addr_b_ff <= pwdata[23:0];
      end
      if (wr_io) begin
        io_addr_ff <= pwdata[7:0];
      end
    end
  end

  // Interrupt and transfer outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff     <= dma0_pkg::IRQ_STATUS_RST;
      mask_ff       <= dma0_pkg::IRQ_MASK_RST;
      irq_ff        <= 1'b0;
      xfer_valid_ff <= 1'b0;
      xfer_ff       <= '0;
    end else begin
      status_ff     <= nxt_status;
      irq_ff        <= |(status_ff & mask_ff);
      xfer_valid_ff <= fire;
      if (wr_mask) begin
        mask_ff <= pwdata[0:0];
      end
      if (fire) begin
        xfer_ff <= nxt_xfer;
      end
    end
  end

  assign prdata       = prdata_ff;
  assign pready       = pready_ff;
  assign pslverr      = pslverr_ff;
  assign xfer_valid   = xfer_valid_ff;
  assign xfer         = xfer_ff;
  assign xfer_enabled = ctrl_ff.xfer_enable_bit;
  assign irq          = irq_ff;

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_final_xfer;
    fire && last && !rpt_mode && ctrl_ff.xfer_irq_enable_bit && !wr_ctrl;
  endsequence

  sequence s_enable_drops;
    !ctrl_ff.xfer_enable_bit && status_ff[dma0_pkg::IRQ_DONE_BIT];
  endsequence

  a_xfer_needs_enable:
    assert property (xfer_valid_ff |-> $past(ctrl_ff.xfer_enable_bit))
    else $error("transfer issued while channel disabled");

  a_tx_select_fires:
    assert property (ctrl_ff.xfer_enable_bit && sel == 3'h4
                     && serial_unit_tx_empty |=> xfer_valid_ff)
    else $error("tx empty select did not start a transfer");

  a_full_from_select:
    assert property (xfer_valid_ff && xfer_ff.full_mode
                     |-> $past(sel[2:1]) == 2'h3)
    else $error("full mode transfer without full mode select");

  a_short_inc_byte:
    assert property (fire && !full_mode && !idle_mode && !last
                     && !ctrl_ff.step_direction_bit
                     && !ctrl_ff.xfer_size_bit && !wr_mar_a
                     |=> mem_addr_a_ff == $past(mem_addr_a_ff) + 24'h1)
    else $error("byte increment wrong");

  a_short_dec_word:
    assert property (fire && !full_mode && !idle_mode && !last
                     && ctrl_ff.step_direction_bit
                     && ctrl_ff.xfer_size_bit && !wr_mar_a
                     |=> mem_addr_a_ff == $past(mem_addr_a_ff) - 24'h2)
    else $error("word decrement wrong");

  a_full_src_fixed:
    assert property (fire && full_mode && !src_step_enable_bit && !wr_mar_a
                     |=> $stable(mem_addr_a_ff))
    else $error("full mode source moved while stepping off");

  a_full_src_down:
    assert property (fire && full_mode && src_step_enable_bit
                     && src_direction_bit && !ctrl_ff.xfer_size_bit
                     && !wr_mar_a
                     |=> mem_addr_a_ff == $past(mem_addr_a_ff) - 24'h1)
    else $error("full mode source decrement wrong");

  a_io_addr_used:
    assert property (xfer_valid_ff |-> xfer_ff.io_address ==
                     (xfer_ff.full_mode ? 8'h00 : $past(io_addr_ff)))
    else $error("io address not passed as expected");

  a_repeat_reload:
    assert property (fire && last && rpt_mode && !wr_cnt && !wr_ctrl
                     |=> count_ff == $past(shadow_count_ff)
                         && ctrl_ff.xfer_enable_bit)
    else $error("repeat mode did not reload");

  a_end_raises_irq:
    assert property (s_final_xfer ##1 s_enable_drops
                     |-> ##1 (irq || !mask_ff[0]))
    else $error("end of transfer gave no interrupt");

  a_no_irq_disabled:
    assert property (finish && !ctrl_ff.xfer_irq_enable_bit
                     && !status_ff[0] |=> !status_ff[0])
    else $error("status set with irq enable clear");

  a_mar_top_ones:
    assert property (pready_ff && psel && !pwrite
                     && (hit_mar_a || hit_mar_b)
                     |-> prdata[31:24] == 8'hff)
    else $error("address top byte not all ones");

  a_io_end_stops:
    assert property (fire && last && io_mode && !wr_ctrl
                     |=> !ctrl_ff.xfer_enable_bit)
    else $error("io mode end did not clear enable");

  a_idle_holds_addr:
    assert property (fire && idle_mode && !wr_mar_a
                     |=> $stable(mem_addr_a_ff))
    else $error("idle mode moved the memory address");

  a_full_src_up:
    assert property (fire && full_mode && src_step_enable_bit
                     && !src_direction_bit && ctrl_ff.xfer_size_bit
                     && !wr_mar_a
                     |=> mem_addr_a_ff == $past(mem_addr_a_ff) + 24'h2)
    else $error("full mode source word increment wrong");

  a_rx_select_fires:
    assert property (ctrl_ff.xfer_enable_bit && sel == 3'h5
                     && serial_unit_rx_full |=> xfer_valid_ff)
    else $error("rx full select did not start a transfer");

  a_timer_select_fires:
    assert property (ctrl_ff.xfer_enable_bit && !sel[2]
                     && timer_unit_evt[sel[1:0]] |=> xfer_valid_ff)
    else $error("timer select did not start a transfer");

  a_status_needs_ie:
    assert property ($rose(status_ff[0])
                     |-> $past(ctrl_ff.xfer_irq_enable_bit))
    else $error("end status raised without irq enable");

endmodule : dma0_chan

// *** test/evt_source.sv ***
`timescale 1ns/100ps
// Activation sources: one-cycle event pulses and the request pin
module evt_source (
  // Clock, reset and command from the bench
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       fire,
  input  wire logic [2:0] code,
  // Events toward the channel
  output      logic [3:0] timer_unit_evt,
  output      logic       serial_unit_tx_empty,
  output      logic       serial_unit_rx_full,
  output      logic       dreq_n
);
  logic [2:0] low_cnt_ff;
  wire        pin_req = fire && (code[2:1] == 2'h3);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_unit_evt       <= 4'h0;
      serial_unit_tx_empty <= 1'b0;
      serial_unit_rx_full  <= 1'b0;
      dreq_n               <= 1'b1;
      low_cnt_ff           <= 3'h0;
    end else begin
      timer_unit_evt       <= 4'h0;
      serial_unit_tx_empty <= fire && (code == 3'h4);
      serial_unit_rx_full  <= fire && (code == 3'h5);
      if (fire && !code[2]) begin
        timer_unit_evt[code[1:0]] <= 1'b1;
      end
      // Pin stays low long enough to pass the channel's synchroniser
      if (pin_req) begin
        low_cnt_ff <= 3'h6;
      end else if (low_cnt_ff != 3'h0) begin
        low_cnt_ff <= low_cnt_ff - 3'h1;
      end
      dreq_n <= !pin_req && (low_cnt_ff <= 3'h1);
    end
  end
endmodule : evt_source

// *** test/dma_channel_zero_regs_test.sv ***
`timescale 1ns/100ps
module dma_channel_zero_regs_test;
  logic            pclk;
  logic            presetn;
  logic            psel;
  logic            penable;
  logic            pwrite;
  logic [11:0]     paddr;
  logic [31:0]     pwdata;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  logic [3:0]      timer_unit_evt;
  logic            serial_unit_tx_empty;
  logic            serial_unit_rx_full;
  logic            dreq_n;
  logic            xfer_valid;
  dma0_pkg::xfer_t xfer;
  logic            xfer_enabled;
  logic            irq;
  logic            fire;
  logic [2:0]      code;
  logic [31:0]     rd;
  logic            err;
  logic [7:0]      ctl;
  logic [23:0]     ea;
  int              n_fail;
  int              n_tests;

  dma0_chan u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .timer_unit_evt,
    .serial_unit_tx_empty, .serial_unit_rx_full, .dreq_n, .xfer_valid,
    .xfer, .xfer_enabled, .irq);
  evt_source u_src (.pclk, .presetn, .fire, .code, .timer_unit_evt,
    .serial_unit_tx_empty, .serial_unit_rx_full, .dreq_n);

  task automatic complete_run();
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Read data and error are taken at the edge where pready is seen
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wrt(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wrt

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task automatic fire_src(input logic [2:0] c);
    @(posedge pclk);
    fire <= 1'b1;
    code <= c;
    @(posedge pclk);
    fire <= 1'b0;
  endtask : fire_src

  // A fixed window, so that absence of a transfer is checked as well
  task automatic wait_xfer(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (12) begin
      @(posedge pclk);
      if (xfer_valid === 1'b1) seen = 1'b1;
    end
    chk({31'h0, seen}, {31'h0, exp});
  endtask : wait_xfer

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    #200us;
    n_fail++;
    complete_run();
  end

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    fire    = 1'b0;
    code    = 3'h0;
    n_fail  = 0;
    n_tests = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(dma0_pkg::ADDR_MEM_ADDR_A, 32'hff000000);
    rdc(dma0_pkg::ADDR_CTRL_A, 32'h0);
    rdc(dma0_pkg::ADDR_IRQ_MASK, 32'h1);
    apb(1'b0, 12'hffc, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    wrt(dma0_pkg::ADDR_MEM_ADDR_B, 32'h3300beef);
    rdc(dma0_pkg::ADDR_MEM_ADDR_B, 32'hff00beef);
    wrt(dma0_pkg::ADDR_IO_ADDR_A, 32'h5a);
    wrt(dma0_pkg::ADDR_CTRL_A, 32'h0);
    fire_src(3'h0);
    wait_xfer(1'b0);
    for (int k = 0; k < 6; k++) begin
      ctl = {1'b1, k[0], k[1], 2'b00, k[2:0]};
      wrt(dma0_pkg::ADDR_MEM_ADDR_A, 32'h5a001000);
      rdc(dma0_pkg::ADDR_MEM_ADDR_A, 32'hff001000);
      wrt(dma0_pkg::ADDR_COUNT_A, 32'h64);
      wrt(dma0_pkg::ADDR_CTRL_A, {24'h0, ctl});
      fire_src(3'((k + 1) % 6));
      wait_xfer(1'b0);
      fire_src(k[2:0]);
      wait_xfer(1'b1);
      chk({8'h0, xfer.source_address}, 32'h1000);
      chk({8'h0, xfer.dest_address}, 32'hbeef);
      chk({24'h0, xfer.io_address}, 32'h5a);
      chk({30'h0, xfer.word, xfer.full_mode}, {30'h0, k[0], 1'b0});
      ea = k[1] ? 24'h1000 - (k[0] ? 24'h2 : 24'h1)
                : 24'h1000 + (k[0] ? 24'h2 : 24'h1);
      rdc(dma0_pkg::ADDR_MEM_ADDR_A, {8'hff, ea});
      rdc(dma0_pkg::ADDR_COUNT_A, 32'h63);
    end
    for (int m = 1; m >= 0; m--) begin
      wrt(dma0_pkg::ADDR_IRQ_MASK, 32'(m));
      wrt(dma0_pkg::ADDR_COUNT_A, 32'h1);
      wrt(dma0_pkg::ADDR_CTRL_A, 32'h88);
      fire_src(3'h0);
      wait_xfer(1'b1);
      chk({31'h0, xfer_enabled}, 32'h0);
      chk({31'h0, irq}, 32'(m));
      rdc(dma0_pkg::ADDR_IRQ_STATUS, 32'h1);
      wrt(dma0_pkg::ADDR_IRQ_STATUS, 32'h1);
      rdc(dma0_pkg::ADDR_IRQ_STATUS, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    wrt(dma0_pkg::ADDR_IRQ_MASK, 32'h1);
    wrt(dma0_pkg::ADDR_COUNT_A, 32'h1);
    wrt(dma0_pkg::ADDR_CTRL_A, 32'h80);
    fire_src(3'h0);
    wait_xfer(1'b1);
    rdc(dma0_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Repeat mode reloads count and address; idle mode holds address
    wrt(dma0_pkg::ADDR_MEM_ADDR_A, 32'h1000);
    wrt(dma0_pkg::ADDR_COUNT_A, 32'h1);
    wrt(dma0_pkg::ADDR_CTRL_A, 32'h90);
    fire_src(3'h0);
    wait_xfer(1'b1);
    chk({31'h0, xfer_enabled}, 32'h1);
    rdc(dma0_pkg::ADDR_MEM_ADDR_A, 32'hff001000);
    rdc(dma0_pkg::ADDR_COUNT_A, 32'h1);
    wrt(dma0_pkg::ADDR_COUNT_A, 32'h5);
    wrt(dma0_pkg::ADDR_CTRL_A, 32'h98);
    fire_src(3'h0);
    wait_xfer(1'b1);
    rdc(dma0_pkg::ADDR_MEM_ADDR_A, 32'hff001000);
    // Full address mode driven by the request pin
    wrt(dma0_pkg::ADDR_COUNT_A, 32'h64);
    wrt(dma0_pkg::ADDR_CTRL_A, 32'hb6);
    fire_src(3'h6);
    wait_xfer(1'b1);
    chk({31'h0, xfer.full_mode}, 32'h1);
    chk({24'h0, xfer.io_address}, 32'h0);
    rdc(dma0_pkg::ADDR_MEM_ADDR_A, 32'hff000fff);
    wrt(dma0_pkg::ADDR_CTRL_A, 32'he7);
    fire_src(3'h7);
    wait_xfer(1'b1);
    rdc(dma0_pkg::ADDR_MEM_ADDR_A, 32'hff000fff);
    wrt(dma0_pkg::ADDR_CTRL_A, 32'hd6);
    fire_src(3'h6);
    wait_xfer(1'b1);
    rdc(dma0_pkg::ADDR_MEM_ADDR_A, 32'hff001001);
    complete_run();
  end
endmodule : dma_channel_zero_regs_test
